//--- hdl/fault_sup_pkg.sv
// shared constants, types and register layout for the converter fault supervisor
// assumes a single 100 MHz core clock and synchronous active-high reset
// How it works
// - overtemperature stops conversion and drives the fault line low.
// - after overtemperature, restart only once temperature is back below threshold.
// - overtemperature sets byte 2 bit 0 of the status register at F0h.
// - an external pull-down of the fault line shuts the device down.
// - fault line pulled low externally sets byte 1 bit 0.
// - absolute output overvoltage shuts the device down.
// - absolute output overvoltage sets byte 0 bit 5.
// - relative overvoltage longer than its timeout shuts the device down.
// - relative overvoltage masked in soft start and one timeout after setpoint change.
// - relative overvoltage sets byte 1 bit 5.
// - amplifier overload longer than its timeout in run shuts down and drives fault line.
// - amplifier overload sets byte 2 bit 2.
// - overcurrent longer than its timeout in soft start or run shuts down.
// - regulator-stage overcurrent sets slow-limit flag, plus negative flag if output negative; multiplier only sets fall flag.
// - overcurrent restart delay chosen by the stage that shut down.
// - short circuit stops quickly, sets fast-limit flags, restarts after protection recovery.
// - input faults, overtemperature and fault line low block restart while present.
// - load faults retry startup repeatedly after a delay.
// - fault line is open drain, released when enabled and fault free.
// - enable floating or high enables; pulled low disables.
package fault_sup_pkg;
    localparam int unsigned CLK_HZ              = 100_000_000;
    localparam int unsigned RELOV_TIMEOUT_US    = 10;
    localparam int unsigned OVLD_TIMEOUT_US     = 10;
    localparam int unsigned OC_TIMEOUT_US       = 10;
    localparam int unsigned PROT_RECOVERY_US    = 30;
    localparam int unsigned OC_RECOVERY_US      = 20;
    localparam int unsigned SOFTSTART_US        = 20;
    localparam int unsigned RELOV_CYC  = RELOV_TIMEOUT_US * (CLK_HZ / 1_000_000);
    localparam int unsigned OVLD_CYC   = OVLD_TIMEOUT_US * (CLK_HZ / 1_000_000);
    localparam int unsigned OC_CYC     = OC_TIMEOUT_US * (CLK_HZ / 1_000_000);
    localparam int unsigned PROT_CYC   = PROT_RECOVERY_US * (CLK_HZ / 1_000_000);
    localparam int unsigned OCREC_CYC  = OC_RECOVERY_US * (CLK_HZ / 1_000_000);
    localparam int unsigned SS_CYC     = SOFTSTART_US * (CLK_HZ / 1_000_000);
    localparam int unsigned TW         = 16;
    localparam int unsigned ECHO_CYC   = 6;
    // enable and fault line idle high, fault comparators idle low
    localparam logic [12:0] SYNC_IDLE  = 13'h1800;

    localparam logic [7:0] FAULT_STATUS_CMD = 8'hF0;
    localparam int unsigned STATUS_W        = 24;
    localparam logic [23:0] STATUS_RESET    = 24'h00_0000;
    // field positions within the 24-bit register
    localparam int unsigned B_IN_UV    = 3;
    localparam int unsigned B_IN_OV    = 4;
    localparam int unsigned B_OUT_OV   = 5;
    localparam int unsigned B_FLT_FALL = 8;
    localparam int unsigned B_NEG_OUT  = 9;
    localparam int unsigned B_Q1_FAST  = 10;
    localparam int unsigned B_Q3_FAST  = 11;
    localparam int unsigned B_Q3_SLOW  = 12;
    localparam int unsigned B_REL_OV   = 13;
    localparam int unsigned B_OT       = 16;
    localparam int unsigned B_OVLD     = 18;

    typedef enum logic [1:0] {
        ST_OFF     = 2'b00,
        ST_START   = 2'b01,
        ST_RUN     = 2'b10,
        ST_RECOVER = 2'b11
    } state_t;
endpackage

//--- hdl/fault_sup_if.sv
// carrier between the supervisor top and its qualification timer
// assumes both ends on the core clock
`timescale 1ns/100ps
`default_nettype none
interface fault_sup_if;
    logic        cond;
    logic [15:0] limit;
    logic        expired;
    modport owner (output cond, output limit, input expired);
    modport timer (input cond, input limit, output expired);
endinterface
`default_nettype wire

//--- hdl/qual_timer.sv
// persistence timer: expired after cond holds continuously beyond limit cycles
// assumes cond is synchronous to clk
`timescale 1ns/100ps
`default_nettype none
module qual_timer (
    input  wire logic clk,
    input  wire logic rst,
    fault_sup_if.timer t
);
    typedef struct packed {
        logic [15:0] cnt;
        logic        exp;
    } tstate_t;
    tstate_t s_q;
    tstate_t s_d;
    always_comb begin
        s_d = s_q;
        if (!t.cond) begin
            s_d.cnt = 16'h0000;
            s_d.exp = 1'b0;
        end else if (s_q.cnt >= t.limit) begin
            s_d.exp = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 16'h0001;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign t.expired = s_q.exp;
endmodule
`default_nettype wire

//--- hdl/fault_supervisor.sv
// converter fault supervisor: detects faults, drives fault line, holds status flags
// assumes comparator levels arrive asynchronously; register read via documented command port
`timescale 1ns/100ps
`default_nettype none
module converter_fault_supervisor (
    // clock and reset
    input  wire logic        CORE_CLK_IN,
    input  wire logic        RESET_IN,
    // comparator and pin levels, asynchronous
    input  wire logic        ENABLE_IN,
    input  wire logic        FAULT_LINE_N_IN,
    input  wire logic        OVERTEMP_IN,
    input  wire logic        IN_UV_IN,
    input  wire logic        IN_OV_IN,
    input  wire logic        OUT_OV_IN,
    input  wire logic        REL_OV_IN,
    input  wire logic        AMP_OVLD_IN,
    input  wire logic        OC_REG_IN,
    input  wire logic        OC_MULT_IN,
    input  wire logic        NEG_OUT_IN,
    input  wire logic        SHORT_Q1_IN,
    input  wire logic        SHORT_Q3_IN,
    // setpoint change pulse, core domain
    input  wire logic        SETPOINT_CHG_IN,
    // command port
    input  wire logic        CMD_RD_IN,
    input  wire logic [7:0]  CMD_CODE_IN,
    input  wire logic        CMD_CLR_IN,
    output logic [23:0]      RD_DATA_OUT,
    output logic             RD_VALID_OUT,
    // power stage and fault line
    output logic             POWER_RUN_OUT,
    output logic             SOFT_START_OUT,
    output logic             FAULT_LINE_N_OUT,
    output logic             FAULT_LINE_N_OE_OUT
);
    localparam int unsigned NSYNC = 13;

    typedef struct packed {
        logic [NSYNC-1:0] s1;
        logic [NSYNC-1:0] s2;
        logic [NSYNC-1:0] s3;
        logic [NSYNC-1:0] lvl;
        fault_sup_pkg::state_t st;
        logic [15:0] cnt;
        logic [15:0] mask_cnt;
        logic        oc_slow_rec;
        logic        self_drive;
        logic [23:0] flags;
        logic [23:0] rd;
        logic        rdv;
        logic [fault_sup_pkg::ECHO_CYC-1:0] echo;
        logic        run;
        logic        ss;
        logic        oe_n;
    } state_s_t;

    state_s_t q;
    state_s_t d;

    logic [NSYNC-1:0] raw;
    logic en, ext_low, ot, uv, ov, oov, rov, ovld, ocr, ocm, neg, sq1, sq3;
    logic rel_ov_q, ovld_q, oc_q;
    logic persist_fault, load_fault, any_fault, ext_pull;
    logic [23:0] set_bits;

    fault_sup_if t_rov ();
    fault_sup_if t_ovl ();
    fault_sup_if t_oc ();

    assign raw = {ENABLE_IN, FAULT_LINE_N_IN, OVERTEMP_IN, IN_UV_IN, IN_OV_IN, OUT_OV_IN, REL_OV_IN,
                  AMP_OVLD_IN, OC_REG_IN, OC_MULT_IN, NEG_OUT_IN, SHORT_Q1_IN, SHORT_Q3_IN};
    assign {en, ext_low, ot, uv, ov, oov, rov, ovld, ocr, ocm, neg, sq1, sq3} = q.lvl;

    // relative overvoltage only counts in run and outside the setpoint mask
    assign t_rov.cond  = rov && (q.st == fault_sup_pkg::ST_RUN) && (q.mask_cnt == 16'h0000);
    assign t_rov.limit = 16'(fault_sup_pkg::RELOV_CYC);
    assign t_ovl.cond  = ovld && (q.st == fault_sup_pkg::ST_RUN);
    assign t_ovl.limit = 16'(fault_sup_pkg::OVLD_CYC);
    assign t_oc.cond   = (ocr || ocm) && (q.st == fault_sup_pkg::ST_RUN || q.st == fault_sup_pkg::ST_START);
    assign t_oc.limit  = 16'(fault_sup_pkg::OC_CYC);
    assign rel_ov_q = t_rov.expired;
    assign ovld_q   = t_ovl.expired;
    assign oc_q     = t_oc.expired;

    qual_timer u_tmr_rov (.clk(CORE_CLK_IN), .rst(RESET_IN), .t(t_rov));
    qual_timer u_tmr_ovl (.clk(CORE_CLK_IN), .rst(RESET_IN), .t(t_ovl));
    qual_timer u_tmr_oc  (.clk(CORE_CLK_IN), .rst(RESET_IN), .t(t_oc));

    // external pull-down counts only once our own drive and its sync echo are gone
    assign ext_pull      = !ext_low && !q.self_drive && (q.echo == '0);
    assign persist_fault = ot || uv || ov || ext_pull;
    assign load_fault    = oov || rel_ov_q || ovld_q || oc_q || sq1 || sq3;
    assign any_fault     = persist_fault || load_fault;

    always_comb begin
        set_bits = 24'h00_0000;
        set_bits[fault_sup_pkg::B_OT]       = ot;
        set_bits[fault_sup_pkg::B_IN_UV]    = uv;
        set_bits[fault_sup_pkg::B_IN_OV]    = ov;
        set_bits[fault_sup_pkg::B_OUT_OV]   = oov;
        set_bits[fault_sup_pkg::B_REL_OV]   = rel_ov_q;
        set_bits[fault_sup_pkg::B_OVLD]     = ovld_q;
        set_bits[fault_sup_pkg::B_FLT_FALL] = ext_pull || (oc_q && ocm && !ocr);
        set_bits[fault_sup_pkg::B_NEG_OUT]  = neg && ((oc_q && ocr) || sq1 || sq3);
        set_bits[fault_sup_pkg::B_Q3_SLOW]  = oc_q && ocr;
        set_bits[fault_sup_pkg::B_Q1_FAST]  = sq1;
        set_bits[fault_sup_pkg::B_Q3_FAST]  = sq3;
    end

    always_comb begin
        d = q;
        d.s1  = raw;
        d.s2  = q.s1;
        d.s3  = q.s2;
        d.echo = {q.echo[fault_sup_pkg::ECHO_CYC-2:0], q.self_drive};
        for (int i = 0; i < NSYNC; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                d.lvl[i] = q.s3[i];
            end
        end
        d.rdv = 1'b0;
        // set wins over clear
        d.flags = (CMD_CLR_IN ? 24'h00_0000 : q.flags) | set_bits;
        if (CMD_RD_IN) begin
            d.rdv = 1'b1;
            d.rd  = (CMD_CODE_IN == fault_sup_pkg::FAULT_STATUS_CMD) ? q.flags : 24'h00_0000;
        end
        if (SETPOINT_CHG_IN) begin
            d.mask_cnt = 16'(fault_sup_pkg::RELOV_CYC);
        end else if (q.mask_cnt != 16'h0000) begin
            d.mask_cnt = q.mask_cnt - 16'h0001;
        end
        case (q.st)
            fault_sup_pkg::ST_OFF: begin
                d.self_drive = 1'b0;
                if (en && !persist_fault && (q.echo == '0)) begin
                    d.st  = fault_sup_pkg::ST_START;
                    d.cnt = 16'(fault_sup_pkg::SS_CYC);
                end
            end
            fault_sup_pkg::ST_START: begin
                d.cnt = q.cnt - 16'h0001;
                if (any_fault || !en) begin
                    d.st         = fault_sup_pkg::ST_RECOVER;
                    d.self_drive = any_fault;
                    d.oc_slow_rec = oc_q && ocm && !ocr;
                    d.cnt        = (oc_q && ocm && !ocr) ? 16'(fault_sup_pkg::OCREC_CYC)
                                                         : 16'(fault_sup_pkg::PROT_CYC);
                end else if (q.cnt == 16'h0000) begin
                    d.st = fault_sup_pkg::ST_RUN;
                end
            end
            fault_sup_pkg::ST_RUN: begin
                if (any_fault || !en) begin
                    d.st          = fault_sup_pkg::ST_RECOVER;
                    d.self_drive  = any_fault;
                    d.oc_slow_rec = oc_q && ocm && !ocr;
                    d.cnt         = (oc_q && ocm && !ocr) ? 16'(fault_sup_pkg::OCREC_CYC)
                                                          : 16'(fault_sup_pkg::PROT_CYC);
                end
            end
            fault_sup_pkg::ST_RECOVER: begin
                // wait until overtemperature and input faults clear, then count recovery
                if (ot || uv || ov) begin
                    d.cnt = q.oc_slow_rec ? 16'(fault_sup_pkg::OCREC_CYC) : 16'(fault_sup_pkg::PROT_CYC);
                end else if (q.cnt != 16'h0000) begin
                    d.cnt = q.cnt - 16'h0001;
                end else begin
                    d.st         = fault_sup_pkg::ST_OFF;
                    d.self_drive = 1'b0;
                end
            end
            default: begin
                d.st = fault_sup_pkg::ST_OFF;
            end
        endcase
        // outputs registered from the next state
        d.run  = (d.st == fault_sup_pkg::ST_START) || (d.st == fault_sup_pkg::ST_RUN);
        d.ss   = (d.st == fault_sup_pkg::ST_START);
        d.oe_n = !d.self_drive;
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (RESET_IN) begin
            q <= '{s1: fault_sup_pkg::SYNC_IDLE, s2: fault_sup_pkg::SYNC_IDLE,
                   s3: fault_sup_pkg::SYNC_IDLE, lvl: fault_sup_pkg::SYNC_IDLE,
                   st: fault_sup_pkg::ST_OFF, cnt: 16'h0000, mask_cnt: 16'h0000,
                   oc_slow_rec: 1'b0, self_drive: 1'b0, flags: fault_sup_pkg::STATUS_RESET,
                   rd: 24'h00_0000, rdv: 1'b0, echo: '0, run: 1'b0, ss: 1'b0, oe_n: 1'b1};
        end else begin
            q <= d;
        end
    end

    assign RD_DATA_OUT         = q.rd;
    assign RD_VALID_OUT        = q.rdv;
    assign POWER_RUN_OUT       = q.run;
    assign SOFT_START_OUT      = q.ss;
    // open drain: always drive low value, enable active low
    assign FAULT_LINE_N_OUT    = 1'b0;
    assign FAULT_LINE_N_OE_OUT = q.oe_n;

    AST_SHUTDOWN_OT: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (ot && q.st == fault_sup_pkg::ST_RUN) |=> (q.st == fault_sup_pkg::ST_RECOVER && q.self_drive))
        else $error("overtemp did not shut down");
    AST_NO_RESTART_OT: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (q.st == fault_sup_pkg::ST_RECOVER && ot) |=> (q.st == fault_sup_pkg::ST_RECOVER))
        else $error("left recovery while hot");
    AST_OT_FLAG: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        ot |=> q.flags[fault_sup_pkg::B_OT])
        else $error("overtemp flag missing");
    AST_FALL_FLAG: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        ext_pull |=> q.flags[fault_sup_pkg::B_FLT_FALL])
        else $error("fault line flag missing");
    AST_OOV_STOP: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (oov && POWER_RUN_OUT) |=> !POWER_RUN_OUT)
        else $error("overvoltage did not stop");
    AST_REL_MASK: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        SETPOINT_CHG_IN |=> !t_rov.cond [*8])
        else $error("relative check not masked");
    AST_OVLD_FLAG: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        $rose(ovld_q) |=> q.flags[fault_sup_pkg::B_OVLD])
        else $error("overload flag missing");
    AST_FLT_DRIVE: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (q.st == fault_sup_pkg::ST_RUN) |-> FAULT_LINE_N_OE_OUT)
        else $error("fault line driven while running");
    AST_OOV_FLAG: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        oov |=> q.flags[fault_sup_pkg::B_OUT_OV])
        else $error("output overvoltage flag missing");
    AST_REL_STOP: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (rel_ov_q && q.st == fault_sup_pkg::ST_RUN) |=> (q.st == fault_sup_pkg::ST_RECOVER))
        else $error("relative overvoltage did not stop");
    AST_REL_FLAG: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        rel_ov_q |=> q.flags[fault_sup_pkg::B_REL_OV])
        else $error("relative overvoltage flag missing");
    AST_OVLD_STOP: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (ovld_q && q.st == fault_sup_pkg::ST_RUN) |=> (q.st == fault_sup_pkg::ST_RECOVER && q.self_drive))
        else $error("overload did not stop");
    AST_OC_STOP: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (oc_q && POWER_RUN_OUT) |=> !POWER_RUN_OUT)
        else $error("overcurrent did not stop");
    AST_SLOW_FLAG: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (oc_q && ocr) |=> q.flags[fault_sup_pkg::B_Q3_SLOW])
        else $error("slow limit flag missing");
    AST_Q1_SHORT: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (sq1 && POWER_RUN_OUT) |=> (!POWER_RUN_OUT && q.flags[fault_sup_pkg::B_Q1_FAST]))
        else $error("stage one short not handled");
    AST_Q3_SHORT: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (sq3 && POWER_RUN_OUT) |=> (!POWER_RUN_OUT && q.flags[fault_sup_pkg::B_Q3_FAST]))
        else $error("stage three short not handled");
    AST_EXT_STOP: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (ext_pull && POWER_RUN_OUT) |=> !POWER_RUN_OUT)
        else $error("external pull-down did not stop");
    AST_HOLD_OFF: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (q.st == fault_sup_pkg::ST_OFF && persist_fault) |=> (q.st == fault_sup_pkg::ST_OFF))
        else $error("started while a persistent fault stands");
    AST_DISABLE: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (!en && POWER_RUN_OUT) |=> !POWER_RUN_OUT)
        else $error("kept running while disabled");
    AST_DRIVE_IN_FAULT: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (q.st == fault_sup_pkg::ST_RECOVER && q.self_drive) |-> !FAULT_LINE_N_OE_OUT)
        else $error("fault line not driven during fault");

    // recovery count expired with no persistent fault left
    sequence s_recover_done;
        (q.st == fault_sup_pkg::ST_RECOVER) && (q.cnt == 16'h0000) && !(ot || uv || ov);
    endsequence
    // back in off with the line released, ready to retry
    sequence s_retry_ready;
        (q.st == fault_sup_pkg::ST_OFF) && !q.self_drive && FAULT_LINE_N_OE_OUT;
    endsequence
    // multiplier-only overcurrent trips from run
    sequence s_mult_oc_trip;
        (q.st == fault_sup_pkg::ST_RUN) && oc_q && ocm && !ocr;
    endsequence
    // recovery loaded with the overcurrent time
    sequence s_oc_slow_wait;
        (q.st == fault_sup_pkg::ST_RECOVER) && q.oc_slow_rec && (q.cnt == 16'(fault_sup_pkg::OCREC_CYC));
    endsequence
    AST_RETRY: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        s_recover_done |=> s_retry_ready)
        else $error("no retry after recovery");
    AST_OC_REC_SEL: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        s_mult_oc_trip |=> s_oc_slow_wait)
        else $error("multiplier overcurrent took wrong recovery");
endmodule
`default_nettype wire

//--- dv/fault_line_partner.sv
// shared open-drain fault line and enable line as seen by other modules
// assumes active-low output enable from the supervisor and pull-ups on both lines
`timescale 1ns/100ps
`default_nettype none
module fault_line_partner (
    // supervisor side
    input  wire logic oe_n_in,
    // other modules pulling the lines
    input  wire logic line_pull_in,
    input  wire logic en_pull_in,
    // resolved levels
    output logic      line_n_out,
    output logic      enable_out
);
    // pull-up unless any party pulls low
    assign line_n_out = (!oe_n_in || line_pull_in) ? 1'b0 : 1'b1;
    // floating enable reads high
    assign enable_out = en_pull_in ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

//--- dv/converter_fault_supervisor_bench.sv
// self-checking bench for the converter fault supervisor
// assumes 100 MHz core clock and the package timing constants
`timescale 1ns/100ps
`default_nettype none
module converter_fault_supervisor_bench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [11:0] src = 12'h000;
    logic        en_pull = 1'b0;
    logic        spc = 1'b0;
    logic        rd = 1'b0;
    logic [7:0]  code = 8'h00;
    logic        clr = 1'b0;
    logic [23:0] rd_data;
    wire logic   line_n, enable, oe_n, drv, run, ss, rd_v;
    logic [23:0] rdq;
    int          errors = 0;
    int          checks_done = 0;
    int          cycles = 0;
    int          low_cycles = 0;
    localparam int PROT = fault_sup_pkg::PROT_CYC;

    always #5 clk = ~clk;

    fault_line_partner fault_line_partner_i (
        .oe_n_in(oe_n), .line_pull_in(src[8]), .en_pull_in(en_pull),
        .line_n_out(line_n), .enable_out(enable));

    converter_fault_supervisor converter_fault_supervisor_i (
        .CORE_CLK_IN(clk), .RESET_IN(rst), .ENABLE_IN(enable), .FAULT_LINE_N_IN(line_n),
        .OVERTEMP_IN(src[7]), .IN_UV_IN(src[10]), .IN_OV_IN(src[11]), .OUT_OV_IN(src[0]),
        .REL_OV_IN(src[1]), .AMP_OVLD_IN(src[2]), .OC_REG_IN(src[3]), .OC_MULT_IN(src[4]),
        .NEG_OUT_IN(src[9]), .SHORT_Q1_IN(src[5]), .SHORT_Q3_IN(src[6]),
        .SETPOINT_CHG_IN(spc), .CMD_RD_IN(rd), .CMD_CODE_IN(code), .CMD_CLR_IN(clr),
        .RD_DATA_OUT(rd_data), .RD_VALID_OUT(rd_v), .POWER_RUN_OUT(run),
        .SOFT_START_OUT(ss), .FAULT_LINE_N_OUT(drv), .FAULT_LINE_N_OE_OUT(oe_n));

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // cycles the supervisor drives the line low, sampled before the edge updates it
    always @(posedge clk) begin
        cycles++;
        if (oe_n === 1'b0) low_cycles++;
        if (cycles == 95000) begin
            errors++;
            summarize();
        end
    end

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic read(input logic [7:0] c);
        @(posedge clk) begin rd <= 1'b1; code <= c; end
        @(posedge clk) rd <= 1'b0;
        #1 check({23'h0, rd_v}, 24'h00_0001);
        rdq = rd_data;
    endtask

    task automatic wait_run();
        int n;
        n = 0;
        while (!(run === 1'b1 && ss === 1'b0) && n < 8000) begin
            @(posedge clk);
            #1;
            n++;
        end
        check({23'h0, run}, 24'h00_0001);
        @(posedge clk) clr <= 1'b1;
        @(posedge clk) clr <= 1'b0;
    endtask

    // drive one source for hold cycles, judge trip, flags and restart delay
    task automatic shot(input int idx, input int hold, input logic trip, input logic [23:0] mask,
                        input int rec, input logic sp);
        int base;
        int n;
        wait_run();
        base = low_cycles;
        @(posedge clk) begin src[idx] <= 1'b1; spc <= sp; end
        @(posedge clk) spc <= 1'b0;
        repeat (hold - 1) @(posedge clk);
        #1;
        if (trip) check({23'h0, run}, 24'h00_0000);
        check({23'h0, low_cycles != base}, {23'h0, trip});
        @(posedge clk) src[idx] <= 1'b0;
        read(8'hF0);
        check(rdq, trip ? mask : 24'h00_0000);
        if (trip) begin
            n = 0;
            while (oe_n !== 1'b1 && n < rec + 50) begin
                @(posedge clk);
                #1;
                n++;
            end
            // whole time the line was held low, from trip to release
            n = low_cycles - base;
            check({23'h0, (n >= rec - 2 && n <= rec + 10)}, 24'h00_0001);
        end
        $display("test done idx=%0d trip=%0d", idx, trip);
    endtask

    task automatic t_overtemp();
        shot(7, 3500, 1'b1, 24'h01_0000, PROT + 3500, 1'b0);
    endtask

    task automatic t_ext_line();
        shot(8, 200, 1'b1, 24'h00_0100, PROT, 1'b0);
    endtask

    task automatic t_abs_ov();
        shot(0, 10, 1'b1, 24'h00_0020, PROT, 1'b0);
    endtask

    task automatic t_rel_ov();
        int lim;
        lim = fault_sup_pkg::RELOV_CYC;
        shot(1, lim - 50, 1'b0, 24'h0, PROT, 1'b0);
        shot(1, lim + 20, 1'b1, 24'h00_2000, PROT, 1'b0);
        shot(1, lim + lim / 2, 1'b0, 24'h0, PROT, 1'b1);
    endtask

    task automatic t_overload();
        int lim;
        lim = fault_sup_pkg::OVLD_CYC;
        shot(2, lim - 50, 1'b0, 24'h0, PROT, 1'b0);
        shot(2, lim + 20, 1'b1, 24'h04_0000, PROT, 1'b0);
    endtask

    task automatic t_overcurrent();
        int lim;
        lim = fault_sup_pkg::OC_CYC;
        shot(3, lim - 50, 1'b0, 24'h0, PROT, 1'b0);
        shot(3, lim + 20, 1'b1, 24'h00_1000, PROT, 1'b0);
        shot(4, lim + 20, 1'b1, 24'h00_0100, fault_sup_pkg::OCREC_CYC, 1'b0);
    endtask

    task automatic t_short();
        shot(5, 10, 1'b1, 24'h00_0400, PROT, 1'b0);
        shot(6, 10, 1'b1, 24'h00_0800, PROT, 1'b0);
        @(posedge clk) src[9] <= 1'b1;
        shot(5, 10, 1'b1, 24'h00_0600, PROT, 1'b0);
        @(posedge clk) src[9] <= 1'b0;
    endtask

    task automatic t_input();
        shot(10, 200, 1'b1, 24'h00_0008, PROT + 200, 1'b0);
        shot(11, 200, 1'b1, 24'h00_0010, PROT + 200, 1'b0);
    endtask

    task automatic t_enable();
        wait_run();
        @(posedge clk) en_pull <= 1'b1;
        repeat (10) @(posedge clk);
        #1 check({22'h0, run, oe_n}, 24'h00_0001);
        @(posedge clk) en_pull <= 1'b0;
        read(8'h00);
        check(rdq, 24'h00_0000);
        check({23'h0, drv}, 24'h00_0000);
        wait_run();
        $display("test done enable");
    endtask

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_overtemp();
        t_ext_line();
        t_abs_ov();
        t_rel_ov();
        t_overload();
        t_overcurrent();
        t_short();
        t_input();
        t_enable();
        summarize();
    end
endmodule
`default_nettype wire
